// ===== hdl/cea_config_eeprom_ctrl.sv
// Configuration EEPROM access controller with RAM mirror and password lock
`timescale 1ns/1ps
module cea_config_eeprom_ctrl #(
  parameter int P_POR_CYC = cea_pkg::POR_REFRESH_CYC,
  parameter int P_BYTE_CYC = cea_pkg::BYTE_XFER_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_lnk_clk,
  input wire logic i_lnk_wr,
  input wire logic i_lnk_rd,
  input wire logic [7:0] i_lnk_addr,
  input wire logic [7:0] i_lnk_wdata,
  output logic o_lnk_ready,
  output logic o_lnk_done,
  output logic [7:0] o_lnk_rdata,
  input wire logic i_backup_supply_state,
  input wire logic i_date_tick,
  output logic o_eeprom_busy_flag,
  output logic o_auto_refresh_disable,
  output logic o_cfg_unlocked
);
  // ==========================================================
  // Elaboration checks
  if (P_POR_CYC < 2 || P_POR_CYC >= 2 ** cea_pkg::CNT_W) begin : g_bad_por
    $error("P_POR_CYC out of range");
  end
  if (P_BYTE_CYC < 2 || P_BYTE_CYC >= 2 ** cea_pkg::CNT_W) begin : g_bad_byte
    $error("P_BYTE_CYC out of range");
  end

  // ==========================================================
  // Declarations
  localparam logic [cea_pkg::CNT_W-1:0] POR_LOAD = cea_pkg::CNT_W'(P_POR_CYC - 1);
  localparam logic [cea_pkg::CNT_W-1:0] BYTE_LOAD = cea_pkg::CNT_W'(P_BYTE_CYC - 1);
  // Link side
  logic lrst_s1_reg, lrst_s2_reg; // Reset carried into the link domain
  logic ack_s1_reg, ack_s2_reg, ack_s3_reg; // Answer toggle synchroniser
  logic req_tgl_reg, pend_reg;
  cea_pkg::cea_req_t req_reg; // Held stable until answered
  logic lnk_ack;
  // Core side
  logic rq_s1_reg, rq_s2_reg, rq_s3_reg; // Request toggle synchroniser
  logic bk_s1_reg, bk_s2_reg; // Supply state synchroniser
  logic ack_tgl_reg;
  logic [7:0] rsp_data_reg; // Read answer, stable while toggle crosses
  logic req_evt, wr_evt, cmd_wr, start_go, daily_go, done;
  cea_pkg::cea_state_t state_reg, cmd_state;
  logic [cea_pkg::CNT_W-1:0] cnt_reg;
  logic busy_reg, prefix_reg, ard_reg;
  logic [7:0] ee_addr_reg, ee_data_reg, rd_mux, nvm_at_addr;
  logic [7:0] pw_reg [cea_pkg::PW_COUNT];
  logic [7:0] cfg_ram [cea_pkg::CFG_COUNT]; // Mirror registers
  logic [7:0] nvm [cea_pkg::EE_DEPTH]; // Non-volatile array, never reset
  logic unlocked;

  // ==========================================================
  // Mirror address helpers
  // mirror address map
  function automatic logic [7:0] cfg_addr(input int idx);
    cfg_addr = (idx == 0) ? cea_pkg::OFS_CFG_SINGLE : 8'(cea_pkg::OFS_CFG_FIRST + 8'(idx - 1));
  endfunction : cfg_addr
  // Mirror slot of an offset, or CFG_COUNT when none
  function automatic int cfg_slot(input logic [7:0] a);
    cfg_slot = cea_pkg::CFG_COUNT;
    if (a == cea_pkg::OFS_CFG_SINGLE) begin
      cfg_slot = 0;
    end else if (a >= cea_pkg::OFS_CFG_FIRST && a <= cea_pkg::OFS_CFG_LAST) begin
      cfg_slot = int'(a - cea_pkg::OFS_CFG_FIRST) + 1;
    end
  endfunction : cfg_slot
  // ==========================================================
  // Link domain
  // Reset reaches the link clock through two flops
  always_ff @(posedge i_lnk_clk) begin
    lrst_s1_reg <= i_rst;
    lrst_s2_reg <= lrst_s1_reg;
  end
  // Answer toggle comes back from the core; the second and third flops feed logic
  always_ff @(posedge i_lnk_clk) begin
    if (lrst_s2_reg) begin
      {ack_s3_reg, ack_s2_reg, ack_s1_reg} <= 3'h0;
    end else begin
      {ack_s3_reg, ack_s2_reg, ack_s1_reg} <= {ack_s2_reg, ack_s1_reg, ack_tgl_reg};
    end
  end
  assign lnk_ack = ack_s2_reg ^ ack_s3_reg;
  // One request in flight; a new one waits for the answer
  always_ff @(posedge i_lnk_clk) begin
    if (lrst_s2_reg) begin
      req_tgl_reg <= 1'b0;
      pend_reg <= 1'b0;
      req_reg <= '0;
    end else if (!pend_reg && (i_lnk_wr || i_lnk_rd)) begin
      // Write wins when both strobes come together
      req_reg <= '{we: i_lnk_wr, addr: i_lnk_addr, wdata: i_lnk_wdata};
      req_tgl_reg <= ~req_tgl_reg;
      pend_reg <= 1'b1;
    end else if (lnk_ack) begin
      pend_reg <= 1'b0;
    end
  end
  assign o_lnk_ready = ~pend_reg;
  // Answer data taken once the toggle has settled
  always_ff @(posedge i_lnk_clk) begin
    if (lrst_s2_reg) begin
      o_lnk_done <= 1'b0;
      o_lnk_rdata <= cea_pkg::RST_BYTE;
    end else begin
      o_lnk_done <= lnk_ack;
      if (lnk_ack) begin
        o_lnk_rdata <= rsp_data_reg;
      end
    end
  end
  // ==========================================================
  // Core domain crossings
  // Request toggle and supply pin pass two flops first
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      {rq_s3_reg, rq_s2_reg, rq_s1_reg, bk_s2_reg, bk_s1_reg} <= 5'h0;
    end else begin
      {rq_s3_reg, rq_s2_reg, rq_s1_reg} <= {rq_s2_reg, rq_s1_reg, req_tgl_reg};
      {bk_s2_reg, bk_s1_reg} <= {bk_s1_reg, i_backup_supply_state};
    end
  end
  assign req_evt = rq_s2_reg ^ rq_s3_reg;
  assign wr_evt = req_evt & req_reg.we;
  assign cmd_wr = wr_evt && req_reg.addr == cea_pkg::OFS_EE_CMD;
  // Answer every request; reads carry the register value
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ack_tgl_reg <= 1'b0;
      rsp_data_reg <= cea_pkg::RST_BYTE;
    end else if (req_evt) begin
      ack_tgl_reg <= ~ack_tgl_reg;
      rsp_data_reg <= req_reg.we ? cea_pkg::RST_BYTE : rd_mux;
    end
  end
  // ==========================================================
  // Register read decode
  // Write-only command and password bytes read as zero
  always_comb begin
    rd_mux = cea_pkg::RST_BYTE;
    if (req_reg.addr == cea_pkg::OFS_STATUS) begin
      rd_mux[cea_pkg::BIT_BUSY] = busy_reg;
      rd_mux[cea_pkg::BIT_BACKUP] = bk_s2_reg;
    end else if (req_reg.addr == cea_pkg::OFS_CTRL1) begin
      rd_mux[cea_pkg::BIT_ARD] = ard_reg;
    end else if (req_reg.addr == cea_pkg::OFS_EE_ADDR) begin
      rd_mux = ee_addr_reg;
    end else if (req_reg.addr == cea_pkg::OFS_EE_DATA) begin
      rd_mux = ee_data_reg;
    end else if (cfg_slot(req_reg.addr) < cea_pkg::CFG_COUNT) begin
      rd_mux = cfg_ram[cfg_slot(req_reg.addr)];
    end
  end
  // ==========================================================
  // Command decode
  // Map a second command byte to its transfer
  always_comb begin
    case (req_reg.wdata)
      cea_pkg::CMD_REFRESH: cmd_state = cea_pkg::ST_REFRESH;
      cea_pkg::CMD_UPDATE: cmd_state = cea_pkg::ST_UPDATE;
      cea_pkg::CMD_RD_BYTE: cmd_state = cea_pkg::ST_RD_BYTE;
      cea_pkg::CMD_WR_BYTE: cmd_state = cea_pkg::ST_WR_BYTE;
      default: cmd_state = cea_pkg::ST_IDLE;
    endcase
  end
  // Prefix is armed only by 00h written while idle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      prefix_reg <= 1'b0;
    end else if (cmd_wr) begin
      prefix_reg <= req_reg.wdata == cea_pkg::CMD_PREFIX && !busy_reg;
    end
  end
  assign start_go = cmd_wr && prefix_reg && !busy_reg && cmd_state != cea_pkg::ST_IDLE
    && !(bk_s2_reg && (cmd_state == cea_pkg::ST_UPDATE || cmd_state == cea_pkg::ST_WR_BYTE));
  assign daily_go = i_date_tick && !busy_reg && !ard_reg && !bk_s2_reg && !start_go;
  assign done = busy_reg && cnt_reg == '0;
  // ==========================================================
  // Transfer sequencer
  // Transfer runs a fixed time; contents move at its end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg <= cea_pkg::ST_REFRESH;
      busy_reg <= 1'b1;
      cnt_reg <= POR_LOAD;
    end else begin
      case (state_reg)
        cea_pkg::ST_IDLE: begin
          if (start_go) begin
            state_reg <= cmd_state;
            busy_reg <= 1'b1;
            // Whole-set moves take as long as the power-on one
            cnt_reg <= (cmd_state == cea_pkg::ST_REFRESH || cmd_state == cea_pkg::ST_UPDATE)
              ? POR_LOAD : BYTE_LOAD;
          end else if (daily_go) begin
            state_reg <= cea_pkg::ST_REFRESH;
            busy_reg <= 1'b1;
            cnt_reg <= POR_LOAD;
          end
        end
        default: begin
          if (done) begin
            state_reg <= cea_pkg::ST_IDLE;
            busy_reg <= 1'b0;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
      endcase
    end
  end
  assign o_eeprom_busy_flag = busy_reg;
  // ==========================================================
  // Host registers
  // Refresh disable and EEPROM operands
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ard_reg <= cea_pkg::RST_ARD;
      ee_addr_reg <= cea_pkg::RST_BYTE;
    end else if (wr_evt) begin
      if (req_reg.addr == cea_pkg::OFS_CTRL1) begin
        ard_reg <= req_reg.wdata[cea_pkg::BIT_ARD];
      end
      // Operands frozen while a transfer uses them
      if (req_reg.addr == cea_pkg::OFS_EE_ADDR && !busy_reg) begin
        ee_addr_reg <= req_reg.wdata;
      end
    end
  end
  assign o_auto_refresh_disable = ard_reg;
  // Data byte: host write or byte read result
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ee_data_reg <= cea_pkg::RST_BYTE;
    end else if (done && state_reg == cea_pkg::ST_RD_BYTE) begin
      ee_data_reg <= nvm_at_addr;
    end else if (wr_evt && req_reg.addr == cea_pkg::OFS_EE_DATA && !busy_reg) begin
      ee_data_reg <= req_reg.wdata;
    end
  end
  // Password entry bytes
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pw_reg <= '{default: cea_pkg::RST_BYTE};
    end else if (wr_evt && req_reg.addr >= cea_pkg::OFS_PW_FIRST
        && req_reg.addr <= cea_pkg::OFS_PW_LAST) begin
      pw_reg[2'(req_reg.addr - cea_pkg::OFS_PW_FIRST)] <= req_reg.wdata;
    end
  end
  always_comb begin
    unlocked = 1'b1;
    for (int i = 0; i < cea_pkg::PW_COUNT; i++) begin
      if (pw_reg[i] != nvm[8'(cea_pkg::OFS_STORED_PASSWORD_FIRST + 8'(i))]) begin
        unlocked = 1'b0;
      end
    end
  end
  assign o_cfg_unlocked = unlocked;
  // ==========================================================
  // Mirror and EEPROM contents
  // Refresh overrides a host write in the same cycle
  always_ff @(posedge i_clk) begin
    if (done && state_reg == cea_pkg::ST_REFRESH) begin
      for (int i = 0; i < cea_pkg::CFG_COUNT; i++) begin
        cfg_ram[i] <= nvm[cfg_addr(i)];
      end
    end else if (wr_evt && unlocked && cfg_slot(req_reg.addr) < cea_pkg::CFG_COUNT) begin
      cfg_ram[cfg_slot(req_reg.addr)] <= req_reg.wdata;
    end
  end
  // Backup supply in the final transfer cycle loses the programming
  always_ff @(posedge i_clk) begin
    if (done && !bk_s2_reg && state_reg == cea_pkg::ST_UPDATE) begin
      for (int i = 0; i < cea_pkg::CFG_COUNT; i++) begin
        nvm[cfg_addr(i)] <= cfg_ram[i];
      end
    end else if (done && !bk_s2_reg && state_reg == cea_pkg::ST_WR_BYTE) begin
      nvm[ee_addr_reg] <= ee_data_reg;
    end
  end
  assign nvm_at_addr = nvm[ee_addr_reg];
  // ==========================================================
  // Assertions
  sequence s_cmd(logic [7:0] code);
    cmd_wr && prefix_reg && !busy_reg && req_reg.wdata == code;
  endsequence
  por_busy_a: assert property (@(posedge i_clk)
    $fell(i_rst) |-> busy_reg && state_reg == cea_pkg::ST_REFRESH)
    else $error("power-on refresh not running");
  status_bit_a: assert property (@(posedge i_clk) disable iff (i_rst)
    req_evt && !req_reg.we && req_reg.addr == cea_pkg::OFS_STATUS
    |=> rsp_data_reg[cea_pkg::BIT_BUSY] == $past(busy_reg))
    else $error("status busy bit wrong");
  busy_ignore_a: assert property (@(posedge i_clk) disable iff (i_rst)
    cmd_wr && busy_reg && cnt_reg > 1 |=> busy_reg && cnt_reg == $past(cnt_reg) - 1'b1)
    else $error("command disturbed running transfer");
  busy_clear_a: assert property (@(posedge i_clk) disable iff (i_rst)
    done |=> !busy_reg && state_reg == cea_pkg::ST_IDLE)
    else $error("busy did not clear");
  daily_go_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_date_tick && !busy_reg && !ard_reg && !bk_s2_reg && !cmd_wr
    |=> state_reg == cea_pkg::ST_REFRESH ##0 cnt_reg == POR_LOAD)
    else $error("daily reload missing");
  daily_skip_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_date_tick && !busy_reg && (ard_reg || bk_s2_reg) && !cmd_wr |=> !busy_reg)
    else $error("daily reload not skipped");
  refresh_cmd_a: assert property (@(posedge i_clk) disable iff (i_rst)
    s_cmd(cea_pkg::CMD_REFRESH) |=> state_reg == cea_pkg::ST_REFRESH && busy_reg)
    else $error("refresh command not started");
  update_cmd_a: assert property (@(posedge i_clk) disable iff (i_rst)
    s_cmd(cea_pkg::CMD_UPDATE) ##0 !bk_s2_reg |=> state_reg == cea_pkg::ST_UPDATE)
    else $error("update command not started");
  rd_byte_a: assert property (@(posedge i_clk) disable iff (i_rst)
    done && state_reg == cea_pkg::ST_RD_BYTE |=> ee_data_reg == $past(nvm_at_addr))
    else $error("byte read result wrong");
  wr_byte_a: assert property (@(posedge i_clk) disable iff (i_rst)
    done && !bk_s2_reg && state_reg == cea_pkg::ST_WR_BYTE
    |=> nvm_at_addr == $past(ee_data_reg))
    else $error("byte write not programmed");
  backup_prog_a: assert property (@(posedge i_clk) disable iff (i_rst)
    s_cmd(cea_pkg::CMD_WR_BYTE) ##0 bk_s2_reg |=> !busy_reg [*2])
    else $error("programming started on backup");
  no_prefix_a: assert property (@(posedge i_clk) disable iff (i_rst)
    cmd_wr && !prefix_reg && !busy_reg && !i_date_tick |=> !busy_reg)
    else $error("unprefixed command started transfer");
endmodule : cea_config_eeprom_ctrl

// ===== hdl/cea_pkg.sv
// Constants and types shared by the configuration EEPROM access controller
package cea_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_STATUS = 8'h0e;
  localparam logic [7:0] OFS_CTRL1 = 8'h0f;
  localparam logic [7:0] OFS_PW_FIRST = 8'h21;
  localparam logic [7:0] OFS_PW_LAST = 8'h24;
  localparam logic [7:0] OFS_EE_ADDR = 8'h25;
  localparam logic [7:0] OFS_EE_DATA = 8'h26;
  localparam logic [7:0] OFS_EE_CMD = 8'h27;
  localparam logic [7:0] OFS_CFG_SINGLE = 8'h2b;
  localparam logic [7:0] OFS_CFG_FIRST = 8'h30;
  localparam logic [7:0] OFS_CFG_LAST = 8'h37;
  // Stored password bytes inside the EEPROM array
  localparam logic [7:0] OFS_STORED_PASSWORD_FIRST = 8'h39;
  // ==========================================================
  // Field positions and reset values
  localparam int BIT_BUSY = 7;
  localparam int BIT_BACKUP = 0;
  localparam int BIT_ARD = 2;
  localparam logic RST_ARD = 1'b0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // ==========================================================
  // Command codes
  localparam logic [7:0] CMD_PREFIX = 8'h00;
  localparam logic [7:0] CMD_UPDATE = 8'h11;
  localparam logic [7:0] CMD_REFRESH = 8'h12;
  localparam logic [7:0] CMD_WR_BYTE = 8'h21;
  localparam logic [7:0] CMD_RD_BYTE = 8'h22;
  // ==========================================================
  // Sizes and timing
  localparam int CFG_COUNT = 9;
  localparam int PW_COUNT = 4;
  localparam int EE_DEPTH = 256;
  localparam int CNT_W = 24;
  localparam int CLK_KHZ = 100000;
  localparam int POR_REFRESH_MS = 66;
  localparam int POR_REFRESH_CYC = POR_REFRESH_MS * CLK_KHZ;
  localparam int BYTE_XFER_MS = 5;
  localparam int BYTE_XFER_CYC = BYTE_XFER_MS * CLK_KHZ;
  // ==========================================================
  // Types
  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cea_req_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_REFRESH, ST_UPDATE, ST_RD_BYTE, ST_WR_BYTE
  } cea_state_t;
endpackage : cea_pkg

// ===== testbench/cea_host_model.sv
// Host-side link master model issuing register requests
`timescale 1ns/1ps
module cea_host_model (
  input wire logic i_lnk_clk,
  input wire logic i_ready,
  input wire logic i_done,
  input wire logic [7:0] i_rdata,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata
);
  // ==========================================
  // Idle levels at time zero
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end

  // ==========================================
  // One request, held until the taking edge, answer taken at done
  task automatic xfer(input logic we, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge i_lnk_clk);
    // Wait for a free link; a hang is caught and failed by the bench watchdog
    while (i_ready !== 1'b1) begin
      @(posedge i_lnk_clk);
    end
    o_wr <= we;
    o_rd <= !we;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_lnk_clk);
    o_wr <= 1'b0;
    o_rd <= 1'b0;
    // Released lines show the inverse so a stale value never passes
    o_addr <= ~a;
    o_wdata <= ~d;
    while (i_done !== 1'b1) begin
      @(posedge i_lnk_clk);
    end
    q = i_rdata;
  endtask : xfer
endmodule : cea_host_model

// ===== testbench/tb_cea_config_eeprom_ctrl.sv
// Self-checking bench for the configuration EEPROM access controller
`timescale 1ns/1ps
module tb_cea_config_eeprom_ctrl;
  // Shortened transfer times keep the run brief
  localparam int POR = 200;
  localparam int BYT = 100;
  logic clk = 1'b0;
  logic lnk_clk = 1'b0;
  logic rst = 1'b1;
  logic backup = 1'b0;
  logic tick = 1'b0;
  logic wr, rd, ready, done, busy, ard, unlocked;
  logic [7:0] addr, wdata, rdata, q;
  int fails = 0;
  int checked = 0;
  int cycles = 0;

  // ==========================================
  // Clocks, the link one offset in phase
  always #5 clk = ~clk;
  initial begin
    #13;
    forever #40 lnk_clk = ~lnk_clk;
  end

  cea_config_eeprom_ctrl #(.P_POR_CYC(POR), .P_BYTE_CYC(BYT)) DUT (
    .i_clk(clk), .i_rst(rst), .i_lnk_clk(lnk_clk), .i_lnk_wr(wr),
    .i_lnk_rd(rd), .i_lnk_addr(addr), .i_lnk_wdata(wdata),
    .o_lnk_ready(ready), .o_lnk_done(done), .o_lnk_rdata(rdata),
    .i_backup_supply_state(backup), .i_date_tick(tick),
    .o_eeprom_busy_flag(busy), .o_auto_refresh_disable(ard),
    .o_cfg_unlocked(unlocked));

  cea_host_model u_host (
    .i_lnk_clk(lnk_clk), .i_ready(ready), .i_done(done), .i_rdata(rdata),
    .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata));

  // ==========================================
  // Verdict and run end
  task automatic complete_run;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  // Hang guard well above the expected length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      fails++;
      complete_run();
    end
  end

  task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, e, g);
    end
  endtask : chk

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] x;
    u_host.xfer(1'b1, a, d, x);
  endtask : wreg

  task automatic rreg(input logic [7:0] a);
    u_host.xfer(1'b0, a, 8'h00, q);
  endtask : rreg

  // Prefix then code, nothing else on the command register between
  task automatic cmd(input logic [7:0] c);
    wreg(cea_pkg::OFS_EE_CMD, cea_pkg::CMD_PREFIX);
    wreg(cea_pkg::OFS_EE_CMD, c);
  endtask : cmd

  // Pause before polling, then a bounded wait for busy to clear
  task automatic idle;
    int n;
    n = 0;
    repeat (8) @(posedge lnk_clk);
    while (busy !== 1'b0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    chk("busy_end", 8'h00, {7'h0, busy});
  endtask : idle

  task automatic ee_wr(input logic [7:0] a, input logic [7:0] d);
    wreg(cea_pkg::OFS_EE_ADDR, a);
    wreg(cea_pkg::OFS_EE_DATA, d);
    cmd(cea_pkg::CMD_WR_BYTE);
    idle();
  endtask : ee_wr

  task automatic ee_rd(input logic [7:0] a);
    wreg(cea_pkg::OFS_EE_ADDR, a);
    cmd(cea_pkg::CMD_RD_BYTE);
    idle();
    rreg(cea_pkg::OFS_EE_DATA);
  endtask : ee_rd

  // Mirrored offsets then stored password offsets
  function automatic logic [7:0] ea(input int i);
    return (i == 0) ? 8'h2b : (i < 9) ? 8'(8'h2f + i) : 8'(8'h30 + i);
  endfunction : ea

  task automatic tick_pulse;
    @(posedge clk) tick <= 1'b1;
    @(posedge clk) tick <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : tick_pulse

  // ==========================================
  // Scenarios
  task automatic t_por;
    int n;
    n = 0;
    chk("por_busy", 8'h01, {7'h0, busy});
    chk("ard_rst", 8'h00, {7'h0, ard});
    while (busy === 1'b1 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    chk("por_len", 8'h01, {7'h0, 1'(n >= POR - 1 && n <= POR + 2)});
    chk("por_clr", 8'h00, {7'h0, busy});
  endtask : t_por

  task automatic t_bytes;
    wreg(cea_pkg::OFS_CTRL1, 8'h04);
    rreg(cea_pkg::OFS_CTRL1);
    chk("ctrl1", 8'h04, q);
    chk("ard_on", 8'h01, {7'h0, ard});
    chk("ready", 8'h01, {7'h0, ready});
    for (int i = 0; i < 13; i++) ee_wr(ea(i), ea(i) ^ 8'h5a);
    for (int i = 0; i < 13; i++) begin
      ee_rd(ea(i));
      chk("ee_byte", ea(i) ^ 8'h5a, q);
    end
  endtask : t_bytes

  task automatic t_busy;
    cmd(cea_pkg::CMD_REFRESH);
    chk("ref_busy", 8'h01, {7'h0, busy});
    rreg(cea_pkg::OFS_STATUS);
    chk("stat_busy", 8'h80, q);
    cmd(cea_pkg::CMD_WR_BYTE);
    idle();
    repeat (5) @(posedge clk);
    chk("no_queue", 8'h00, {7'h0, busy});
    rreg(cea_pkg::OFS_STATUS);
    chk("stat_idle", 8'h00, q);
  endtask : t_busy

  task automatic t_lock;
    for (int i = 0; i < 4; i++) wreg(8'(8'h21 + i), ea(9 + i) ^ 8'h5a);
    chk("unlock", 8'h01, {7'h0, unlocked});
    wreg(8'h30, 8'ha5);
    rreg(8'h30);
    chk("mir_wr", 8'ha5, q);
    cmd(cea_pkg::CMD_REFRESH);
    idle();
    rreg(8'h30);
    chk("mir_ref", 8'h6a, q);
    rreg(8'h2b);
    chk("mir_2b", 8'h71, q);
    rreg(8'h38);
    chk("unmapped", 8'h00, q);
    wreg(8'h31, 8'hc3);
    cmd(cea_pkg::CMD_UPDATE);
    idle();
    ee_rd(8'h31);
    chk("ee_upd", 8'hc3, q);
    wreg(8'h24, 8'h00);
    chk("relock", 8'h00, {7'h0, unlocked});
    wreg(8'h30, 8'h11);
    rreg(8'h30);
    chk("mir_lock", 8'h6a, q);
  endtask : t_lock

  task automatic t_bad;
    wreg(cea_pkg::OFS_EE_CMD, cea_pkg::CMD_WR_BYTE);
    repeat (3) @(posedge clk);
    chk("no_prefix", 8'h00, {7'h0, busy});
    cmd(8'h33);
    repeat (3) @(posedge clk);
    chk("bad_code", 8'h00, {7'h0, busy});
  endtask : t_bad

  task automatic t_supply;
    @(posedge clk) backup <= 1'b1;
    repeat (5) @(posedge clk);
    rreg(cea_pkg::OFS_STATUS);
    chk("stat_bkp", 8'h01, q);
    cmd(cea_pkg::CMD_WR_BYTE);
    repeat (3) @(posedge clk);
    chk("bkp_prog", 8'h00, {7'h0, busy});
    wreg(cea_pkg::OFS_CTRL1, 8'h00);
    tick_pulse();
    chk("bkp_tick", 8'h00, {7'h0, busy});
    wreg(cea_pkg::OFS_CTRL1, 8'h04);
    @(posedge clk) backup <= 1'b0;
    repeat (5) @(posedge clk);
    tick_pulse();
    chk("ard_tick", 8'h00, {7'h0, busy});
    wreg(cea_pkg::OFS_CTRL1, 8'h00);
    chk("ard_off", 8'h00, {7'h0, ard});
    tick_pulse();
    chk("day_tick", 8'h01, {7'h0, busy});
    idle();
  endtask : t_supply

  // ==========================================
  // Main sequence
  initial begin
    repeat (48) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_por();
    t_bytes();
    t_busy();
    t_lock();
    t_bad();
    t_supply();
    complete_run();
  end
endmodule : tb_cea_config_eeprom_ctrl
